// >>> src/bcmc_map.svh
// Register offsets, field positions, reset values and timing counts for the converter control block
`ifndef BCMC_MAP_SVH
`define BCMC_MAP_SVH

// Register offsets (plain port, 8-bit address)
`define BCMC_ADDR_CONV_CFG 8'h00
`define BCMC_ADDR_CORE_CFG 8'h01
`define BCMC_ADDR_MAIN_SET 8'h02
`define BCMC_ADDR_CORE_SET 8'h03
`define BCMC_ADDR_STATUS 8'h04
`define BCMC_ADDR_INT_STAT 8'h05
`define BCMC_ADDR_INT_MASK 8'h06
`define BCMC_ADDR_CONTROL 8'h07

// converter_config_primary fields
`define BCMC_CFG_FORCE_PWM 7
`define BCMC_CFG_SLEEP_EN 6
`define BCMC_CFG_MAIN_DISCH 5
`define BCMC_CFG_PSAVE_OFF 4

// core_voltage_config fields
`define BCMC_CORE_DISCH 7
`define BCMC_CORE_SLEEP_OFF 6
`define BCMC_CORE_LOW_LSB 0

// Voltage codes, 10 mV steps; the core low-voltage field counts 80 mV steps
`define BCMC_MAIN_V30 9'h12C
`define BCMC_MAIN_V33 9'h14A
`define BCMC_CORE_V15 9'h096
`define BCMC_CORE_V16 9'h0A0
`define BCMC_CORE_LOW_RST 6'h0F

// Timing: 1.25 MHz switching from 125 MHz gives 100 cycles per period
`define BCMC_CLK_MHZ 125
`define BCMC_SW_KHZ 1250
`define BCMC_SW_PERIOD ((`BCMC_CLK_MHZ * 1000) / `BCMC_SW_KHZ)
`define BCMC_CORE_PHASE ((`BCMC_SW_PERIOD * 270) / 360)
`define BCMC_DEAD_NS 16
`define BCMC_DEAD_CYC ((`BCMC_DEAD_NS * `BCMC_CLK_MHZ + 999) / 1000)
`define BCMC_SS_STEPS 4
`define BCMC_SS_STEP_PERIODS 64

`endif

// >>> src/bcmc_pkg.sv
// Types for the converter control block
package bcmc_pkg;
	typedef enum logic [1:0] {
		BCMC_PWM = 2'b00,
		BCMC_PFM_RUN = 2'b01,
		BCMC_PFM_IDLE = 2'b11
	} bcmc_mode_e;
	typedef enum logic [1:0] {
		BCMC_SW_OFF = 2'b00,
		BCMC_SW_HIGH = 2'b01,
		BCMC_SW_DEAD = 2'b11,
		BCMC_SW_LOW = 2'b10
	} bcmc_sw_e;
endpackage

// >>> src/bcmc_top.sv
// Mode, voltage and switching control for the main and core step-down converters
// Functional notes
// - Main rail starts 3.0/3.3 V from strap
// - Core rail starts 1.5/1.6 V from strap
// - Host may rewrite both voltage settings
// - Deep sleep lowers or disables core rail
// - Sleep pin ignored without enable bit
// - Auto PFM at light load, can be disabled
// - Bit 7 forces both converters to PWM
// - PFM bursts below low, stops at high
// - Falling to nominal exits power save
// - Main is master, core lags 270 degrees
// - Current limit ramps in four steps
// - Discharge off at reset, enabled per converter
// - Power-good flags readable with hysteresis
// - Power-good loss raises maskable interrupt
// - Power-good ignored while converter disabled
// - Overtemperature shutdown only while in PWM
// - High side on per cycle, dead time
// - Dropout holds high side fully on; in PFM idle the code keeps it off
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "bcmc_map.svh"

module bcmc_top
	import bcmc_pkg::*;
#(
	parameter int SS_STEP_PERIODS = `BCMC_SS_STEP_PERIODS
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Pins
	input wire logic main_default_strap,
	input wire logic core_default_strap,
	input wire logic deep_sleep_pin,
	// Analog comparators and events, per converter [0]=main [1]=core
	input wire logic [1:0] conv_enable,
	input wire logic [1:0] light_load,
	input wire logic [1:0] comp_low,
	input wire logic [1:0] comp_high,
	input wire logic [1:0] comp_nominal,
	input wire logic [1:0] pwm_trip,
	input wire logic [1:0] ilimit_trip,
	input wire logic [1:0] dropout,
	input wire logic [1:0] pg_below10,
	input wire logic [1:0] pg_above5,
	input wire logic overtemp,
	input wire logic undervoltage,
	input wire logic battery_cover_event,
	// Converter controls
	output logic [8:0] main_rail_target,
	output logic [8:0] core_rail_target,
	output logic [1:0] conv_run,
	output logic [1:0] high_side_on,
	output logic [1:0] rectifier_on,
	output logic [1:0] pfm_active,
	output logic [1:0] ilimit_step0,
	output logic [1:0] ilimit_step1,
	output logic [1:0] discharge_on,
	output logic irq
);

	localparam int PER = `BCMC_SW_PERIOD;
	localparam int PH = `BCMC_CORE_PHASE;
	localparam int DEAD = `BCMC_DEAD_CYC;

	logic rst_s1_reg, rst_sync_reg;
	logic [4:0] pin_s1_reg, pin_s2_reg;
	logic [19:0] ain_s1_reg, ain_s2_reg;
	logic [7:0] cfg_reg, core_cfg_reg, int_mask_reg, int_stat_reg;
	logic [8:0] main_set_reg, core_set_reg;
	logic strap_done_reg;
	logic [1:0] strap_wait_reg;
	logic [6:0] phase_reg;
	logic [1:0] tick;
	logic [1:0] pg_reg, pg_fall;
	logic [1:0] en_eff, shutdown_reg, ot_trip;
	logic sleep_act, force_pwm, psave_off;
	logic [1:0] s_enable, s_light, s_low, s_high, s_nom, s_trip, s_ilim, s_drop, s_b10, s_a5;
	logic s_sleep, s_ot, s_uv, s_cover, s_strap_main, s_strap_core;
	bcmc_mode_e mode_reg [2];
	bcmc_sw_e sw_reg [2];
	logic [2:0] dead_cnt_reg [2];
	logic [1:0] ss_step_reg [2];
	logic [15:0] ss_cnt_reg [2];

	// Reset release through two flops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_sync_reg <= rst_s1_reg;
		end
	end

	// Pins and analog comparators are asynchronous to clk_sys
	always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			pin_s1_reg <= 5'h00;
			pin_s2_reg <= 5'h00;
			ain_s1_reg <= 20'h00000;
			ain_s2_reg <= 20'h00000;
		end else begin
			pin_s1_reg <= {main_default_strap, core_default_strap, deep_sleep_pin, undervoltage, battery_cover_event};
			pin_s2_reg <= pin_s1_reg;
			ain_s1_reg <= {conv_enable, light_load, comp_low, comp_high, comp_nominal,
				pwm_trip, ilimit_trip, dropout, pg_below10, pg_above5};
			ain_s2_reg <= ain_s1_reg;
		end
	end

	assign {s_strap_main, s_strap_core, s_sleep, s_uv, s_cover} = pin_s2_reg;
	assign {s_enable, s_light, s_low, s_high, s_nom, s_trip, s_ilim, s_drop, s_b10, s_a5} = ain_s2_reg;

	logic ot_s1_reg, ot_s2_reg;
	always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			ot_s1_reg <= 1'b0;
			ot_s2_reg <= 1'b0;
		end else begin
			ot_s1_reg <= overtemp;
			ot_s2_reg <= ot_s1_reg;
		end
	end
	assign s_ot = ot_s2_reg;

	assign force_pwm = cfg_reg[`BCMC_CFG_FORCE_PWM];
	assign psave_off = cfg_reg[`BCMC_CFG_PSAVE_OFF];
	assign sleep_act = s_sleep && cfg_reg[`BCMC_CFG_SLEEP_EN];

	// Any converter in PWM arms the thermal detector
	assign ot_trip[0] = s_ot && ((mode_reg[0] == BCMC_PWM) || (mode_reg[1] == BCMC_PWM));
	assign ot_trip[1] = ot_trip[0];

	assign en_eff[0] = s_enable[0] && !shutdown_reg[0];
	assign en_eff[1] = s_enable[1] && !shutdown_reg[1] && !(sleep_act && core_cfg_reg[`BCMC_CORE_SLEEP_OFF]);

	// Registers, host writes; voltage settings loaded from straps once after reset
	always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			cfg_reg <= 8'h00;
			core_cfg_reg <= {2'h0, `BCMC_CORE_LOW_RST};
			int_mask_reg <= 8'h00;
			main_set_reg <= `BCMC_MAIN_V30;
			core_set_reg <= `BCMC_CORE_V15;
			strap_done_reg <= 1'b0;
			strap_wait_reg <= 2'h0;
		end else begin
			// Straps are read only once both sync stages hold them, not their reset zeros
			if (strap_wait_reg != 2'h2) begin
				strap_wait_reg <= strap_wait_reg + 2'h1;
			end else if (!strap_done_reg) begin
				strap_done_reg <= 1'b1;
				main_set_reg <= s_strap_main ? `BCMC_MAIN_V33 : `BCMC_MAIN_V30;
				core_set_reg <= s_strap_core ? `BCMC_CORE_V16 : `BCMC_CORE_V15;
			end else if (reg_wr) begin
				unique case (reg_addr)
					`BCMC_ADDR_CONV_CFG: cfg_reg <= reg_wdata;
					`BCMC_ADDR_CORE_CFG: core_cfg_reg <= reg_wdata;
					`BCMC_ADDR_MAIN_SET: main_set_reg <= {reg_wdata, 1'b0};
					`BCMC_ADDR_CORE_SET: core_set_reg <= {1'b0, reg_wdata};
					`BCMC_ADDR_INT_MASK: int_mask_reg <= reg_wdata;
					default: ;
				endcase
			end
		end
	end

	// Shutdown latch on overtemperature, undervoltage or cover; released when cause clears
	always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			shutdown_reg <= 2'b00;
		end else if (ot_trip[0] || s_uv || s_cover) begin
			shutdown_reg <= 2'b11;
		end else if (!s_ot) begin
			shutdown_reg <= 2'b00;
		end
	end

	// Master phase counter; core starts 270 degrees after main
	always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			phase_reg <= 7'h00;
		end else if (phase_reg == 7'(PER - 1)) begin
			phase_reg <= 7'h00;
		end else begin
			phase_reg <= phase_reg + 7'h01;
		end
	end
	assign tick[0] = (phase_reg == 7'h00);
	assign tick[1] = (phase_reg == 7'(PH));

	// Power-good hysteresis, events and interrupt status
	always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			pg_reg <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (!en_eff[i]) begin
					pg_reg[i] <= 1'b0;
				end else if (s_b10[i]) begin
					pg_reg[i] <= 1'b0;
				end else if (s_a5[i]) begin
					pg_reg[i] <= 1'b1;
				end
			end
		end
	end
	assign pg_fall = pg_reg & ~{en_eff[1] ? !s_b10[1] : 1'b1, en_eff[0] ? !s_b10[0] : 1'b1} & en_eff;

	// Read clears status, a new event in that cycle still sets
	always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			int_stat_reg <= 8'h00;
		end else begin
			int_stat_reg <= ((reg_rd && reg_addr == `BCMC_ADDR_INT_STAT) ? 8'h00 : int_stat_reg)
				| {5'h00, ot_trip[0], pg_fall};
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			irq <= 1'b0;
			reg_rdata <= 8'h00;
		end else begin
			irq <= |(int_stat_reg & int_mask_reg);
			if (reg_rd) begin
				unique case (reg_addr)
					`BCMC_ADDR_CONV_CFG: reg_rdata <= cfg_reg;
					`BCMC_ADDR_CORE_CFG: reg_rdata <= core_cfg_reg;
					`BCMC_ADDR_MAIN_SET: reg_rdata <= main_set_reg[8:1];
					`BCMC_ADDR_CORE_SET: reg_rdata <= core_set_reg[7:0];
					`BCMC_ADDR_STATUS: reg_rdata <= {shutdown_reg[0], pfm_active, en_eff, 1'b0, pg_reg};
					`BCMC_ADDR_INT_STAT: reg_rdata <= int_stat_reg;
					`BCMC_ADDR_INT_MASK: reg_rdata <= int_mask_reg;
					default: reg_rdata <= 8'h00;
				endcase
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// Per-converter mode, switching and soft start
	for (genvar g = 0; g < 2; g++) begin : g_conv
		always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
			if (!rst_sync_reg) begin
				mode_reg[g] <= BCMC_PWM;
			end else if (!en_eff[g] || force_pwm || psave_off) begin
				mode_reg[g] <= BCMC_PWM;
			end else begin
				unique case (mode_reg[g])
					BCMC_PWM: if (s_light[g]) mode_reg[g] <= BCMC_PFM_RUN;
					BCMC_PFM_RUN: begin
						if (!s_nom[g]) mode_reg[g] <= BCMC_PWM;
						else if (s_high[g]) mode_reg[g] <= BCMC_PFM_IDLE;
					end
					BCMC_PFM_IDLE: begin
						if (!s_nom[g]) mode_reg[g] <= BCMC_PWM;
						else if (s_low[g]) mode_reg[g] <= BCMC_PFM_RUN;
					end
					default: mode_reg[g] <= BCMC_PWM;
				endcase
			end
		end

		// Burst at half rate: only every second period starts in PFM
		logic odd_reg;
		always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
			if (!rst_sync_reg) begin
				odd_reg <= 1'b0;
			end else if (tick[g]) begin
				odd_reg <= !odd_reg;
			end
		end

		always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
			if (!rst_sync_reg) begin
				sw_reg[g] <= BCMC_SW_OFF;
				dead_cnt_reg[g] <= 3'h0;
			end else if (!en_eff[g] || mode_reg[g] == BCMC_PFM_IDLE) begin
				sw_reg[g] <= BCMC_SW_OFF;
			end else if (s_drop[g]) begin
				sw_reg[g] <= BCMC_SW_HIGH;
			end else if (tick[g] && (mode_reg[g] == BCMC_PWM || odd_reg)) begin
				sw_reg[g] <= BCMC_SW_HIGH;
			end else begin
				unique case (sw_reg[g])
					BCMC_SW_HIGH: if (s_trip[g] || s_ilim[g]) begin
						sw_reg[g] <= BCMC_SW_DEAD;
						dead_cnt_reg[g] <= 3'(DEAD);
					end
					BCMC_SW_DEAD: begin
						if (dead_cnt_reg[g] <= 3'h1) sw_reg[g] <= BCMC_SW_LOW;
						dead_cnt_reg[g] <= dead_cnt_reg[g] - 3'h1;
					end
					default: ;
				endcase
			end
		end

		// Current limit steps up once per SS_STEP_PERIODS switching periods
		always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
			if (!rst_sync_reg) begin
				ss_step_reg[g] <= 2'h0;
				ss_cnt_reg[g] <= 16'h0000;
			end else if (!en_eff[g]) begin
				ss_step_reg[g] <= 2'h0;
				ss_cnt_reg[g] <= 16'h0000;
			end else if (tick[g] && ss_step_reg[g] != 2'(`BCMC_SS_STEPS - 1)) begin
				if (ss_cnt_reg[g] == 16'(SS_STEP_PERIODS - 1)) begin
					ss_cnt_reg[g] <= 16'h0000;
					ss_step_reg[g] <= ss_step_reg[g] + 2'h1;
				end else begin
					ss_cnt_reg[g] <= ss_cnt_reg[g] + 16'h0001;
				end
			end
		end

		always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
			if (!rst_sync_reg) begin
				conv_run[g] <= 1'b0;
				high_side_on[g] <= 1'b0;
				rectifier_on[g] <= 1'b0;
				pfm_active[g] <= 1'b0;
				ilimit_step0[g] <= 1'b0;
				ilimit_step1[g] <= 1'b0;
				discharge_on[g] <= 1'b0;
			end else begin
				conv_run[g] <= en_eff[g];
				high_side_on[g] <= (sw_reg[g] == BCMC_SW_HIGH);
				rectifier_on[g] <= (sw_reg[g] == BCMC_SW_LOW);
				pfm_active[g] <= (mode_reg[g] != BCMC_PWM);
				ilimit_step0[g] <= ss_step_reg[g][0];
				ilimit_step1[g] <= ss_step_reg[g][1];
				discharge_on[g] <= shutdown_reg[g] && (g == 0 ? cfg_reg[`BCMC_CFG_MAIN_DISCH]
					: core_cfg_reg[`BCMC_CORE_DISCH]);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			main_rail_target <= `BCMC_MAIN_V30;
			core_rail_target <= `BCMC_CORE_V15;
		end else begin
			main_rail_target <= main_set_reg;
			core_rail_target <= sleep_act ? {3'h0, core_cfg_reg[5:0]} << 3 : core_set_reg;
		end
	end

endmodule

// >>> test/bcmc_host.sv
// Host processor model: register port master and sleep pin
`timescale 1ns/100ps
module bcmc_host (
	// Clock
	input wire logic clk_sys,
	// Register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Pin
	output logic deep_sleep_pin
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		deep_sleep_pin = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		// Stale data is not left on the bus
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic sleep(input logic v);
		@(posedge clk_sys);
		deep_sleep_pin <= v;
	endtask
endmodule

// >>> test/bcmc_props.sv
// Concurrent checks on the converter control ports
`timescale 1ns/100ps
`include "bcmc_map.svh"
module bcmc_props (
	// Clock, reset and register port
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Converter side
	input wire logic [1:0] conv_enable,
	input wire logic [1:0] dropout,
	input wire logic overtemp,
	input wire logic [1:0] conv_run,
	input wire logic [1:0] high_side_on,
	input wire logic [1:0] rectifier_on,
	input wire logic [1:0] pfm_active
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Copy of the force bit; the port sees a write before the mode logic does, hence settle time below
	logic force_reg;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			force_reg <= 1'b0;
		else if (reg_wr && reg_addr == `BCMC_ADDR_CONV_CFG)
			force_reg <= reg_wdata[`BCMC_CFG_FORCE_PWM];
	end
	a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its slot");
	a_force_no_pfm: assert property (force_reg [*6] |-> pfm_active == 2'b00)
		else $error("power save while forced PWM");
	a_switch_exclusive: assert property (!(|(high_side_on & rectifier_on)))
		else $error("switch and rectifier on together");
	a_dead_main: assert property ($fell(high_side_on[0]) |-> !rectifier_on[0] ##1 !rectifier_on[0])
		else $error("main dead time short");
	a_dead_core: assert property ($fell(high_side_on[1]) |-> (!rectifier_on[1]) [*2])
		else $error("core dead time short");
	a_disabled_idle: assert property ((!conv_enable[0]) [*5] |-> !conv_run[0])
		else $error("main runs while disabled");
	a_hot_stop: assert property ((overtemp && pfm_active == 2'b00) [*6] |-> conv_run == 2'b00)
		else $error("no shutdown on overtemperature");
	a_dropout_full: assert property ((dropout[0] && conv_run[0] && !pfm_active[0]) [*5] |-> high_side_on[0])
		else $error("dropout does not hold switch on");
endmodule

// >>> test/tb_buck_converter_mode_control.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`include "bcmc_map.svh"
module tb_buck_converter_mode_control;
	logic clk_sys, rst_n, main_default_strap, core_default_strap, overtemp, undervoltage, battery_cover_event;
	logic [1:0] conv_enable, light_load, comp_low, comp_high, comp_nominal, pwm_trip, ilimit_trip, dropout;
	logic [1:0] pg_below10, pg_above5, conv_run, high_side_on, rectifier_on, pfm_active;
	logic [1:0] ilimit_step0, ilimit_step1, discharge_on;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic reg_wr, reg_rd, deep_sleep_pin, irq;
	logic [8:0] main_rail_target, core_rail_target, cset;
	int errors = 0;
	int comparisons = 0;
	int n;
	// Short soft-start steps keep the run brief
	bcmc_top #(.SS_STEP_PERIODS(2)) dut_u (.*);
	bcmc_host host_u (.*);
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic chk(input string s, input logic [8:0] e, input logic [8:0] v);
		comparisons++;
		if (v !== e) begin
			errors++;
			$display("ERROR %s exp %h got %h", s, e, v);
		end
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge clk_sys);
		#1;
	endtask
	task automatic gap(input int i, output int k);
		logic p;
		k = 0;
		do begin
			p = high_side_on[i];
			@(posedge clk_sys);
			#1;
			k++;
		end while ((p || !high_side_on[i]) && k < 300);
	endtask
	task automatic wrap_up();
		if (errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		wrap_up();
	end
	initial begin
		rst_n = 1'b0;
		{main_default_strap, core_default_strap, overtemp, undervoltage, battery_cover_event} = 5'h00;
		{conv_enable, light_load, comp_low, comp_high, comp_nominal} = 10'h303;
		{pwm_trip, ilimit_trip, dropout, pg_below10, pg_above5} = 10'h303;
		n = $urandom(32'h2786);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			rst_n <= 1'b0;
			{main_default_strap, core_default_strap} <= 2'(i);
			repeat (20) @(posedge clk_sys);
			rst_n <= 1'b1;
			settle(12);
			chk("main_rail_target", i[1] ? `BCMC_MAIN_V33 : `BCMC_MAIN_V30, main_rail_target);
			chk("core_rail_target", i[0] ? `BCMC_CORE_V16 : `BCMC_CORE_V15, core_rail_target);
			chk("discharge_on", 9'h000, discharge_on);
			chk("ilimit_step", 9'h000, {ilimit_step1, ilimit_step0});
		end
		settle(1000);
		chk("ilimit_step", 9'h00F, {ilimit_step1, ilimit_step0});
		gap(0, n);
		gap(1, n);
		chk("core_lag", 9'd75, 9'(n));
		gap(0, n);
		chk("main_rest", 9'd25, 9'(n));
		repeat (4) begin
			d = 8'($urandom);
			cset = 9'($urandom_range(255));
			host_u.wr(`BCMC_ADDR_MAIN_SET, ~cset[7:0]);
			host_u.wr(`BCMC_ADDR_CORE_SET, cset[7:0]);
			host_u.rd(8'($urandom_range(255, 8)), d[7:0]);
			chk("unmapped_read", 9'h000, d); // Answer for a read off the map
			settle(4);
		end
		chk("core_rail_target", cset, core_rail_target);
		chk("main_rail_target", {~cset[7:0], 1'b0}, main_rail_target);
		host_u.wr(`BCMC_ADDR_CORE_CFG, 8'h2A);
		host_u.sleep(1'b1);
		settle(8);
		chk("core_rail_target", cset, core_rail_target);
		host_u.wr(`BCMC_ADDR_CONV_CFG, 8'h40);
		settle(8);
		chk("core_rail_target", {6'h2A, 3'b000}, core_rail_target);
		host_u.wr(`BCMC_ADDR_CORE_CFG, 8'h6A);
		settle(8);
		chk("conv_run", 9'h001, conv_run);
		host_u.sleep(1'b0);
		host_u.wr(`BCMC_ADDR_CONV_CFG, 8'h00);
		light_load <= 2'b11;
		settle(10);
		chk("pfm_active", 9'h003, pfm_active);
		{light_load, comp_nominal} <= 4'h0;
		settle(8);
		chk("pfm_active", 9'h000, pfm_active);
		{light_load, comp_nominal} <= 4'hF;
		host_u.wr(`BCMC_ADDR_CONV_CFG, 8'h80);
		settle(10);
		chk("pfm_active", 9'h000, pfm_active);
		host_u.wr(`BCMC_ADDR_CONV_CFG, 8'h10);
		settle(10);
		chk("pfm_active", 9'h000, pfm_active);
		{light_load, comp_nominal} <= 4'h0;
		settle(8);
		comp_nominal <= 2'b11;
		host_u.wr(`BCMC_ADDR_INT_MASK, 8'h07);
		pg_below10 <= 2'b01;
		settle(6);
		chk("irq", 9'h001, irq);
		pg_below10 <= 2'b00;
		host_u.rd(`BCMC_ADDR_INT_STAT, d);
		chk("int_status", 9'h001, d);
		host_u.rd(`BCMC_ADDR_INT_STAT, d);
		settle(2);
		chk("int_status", 9'h000, d);
		chk("irq", 9'h000, irq);
		host_u.wr(`BCMC_ADDR_INT_MASK, 8'h00);
		pg_below10 <= 2'b10;
		settle(6);
		chk("irq", 9'h000, irq);
		pg_below10 <= 2'b00;
		host_u.rd(`BCMC_ADDR_INT_STAT, d);
		chk("int_status", 9'h002, d);
		conv_enable <= 2'b10;
		settle(6);
		pg_below10 <= 2'b01;
		settle(6);
		pg_below10 <= 2'b00;
		host_u.rd(`BCMC_ADDR_INT_STAT, d);
		chk("int_status", 9'h000, d);
		conv_enable <= 2'b11;
		host_u.wr(`BCMC_ADDR_CONV_CFG, 8'h20);
		host_u.wr(`BCMC_ADDR_CORE_CFG, 8'h80);
		undervoltage <= 1'b1;
		settle(8);
		chk("conv_run", 9'h000, conv_run);
		chk("discharge_on", 9'h003, discharge_on);
		undervoltage <= 1'b0;
		host_u.wr(`BCMC_ADDR_CORE_CFG, 8'h00);
		overtemp <= 1'b1;
		settle(8);
		chk("conv_run", 9'h000, conv_run);
		chk("discharge_on", 9'h001, discharge_on);
		overtemp <= 1'b0;
		settle(1000);
		dropout <= 2'b01;
		settle(20);
		dropout <= 2'b00;
		repeat (300) begin
			@(posedge clk_sys);
			{comp_low, comp_high, ilimit_trip, pg_above5, battery_cover_event} <= 9'($urandom);
		end
		wrap_up();
	end
endmodule
bind bcmc_top bcmc_props props_u (.*);
